// ==== bench/fpes_array_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Flash array: 8 blocks of two double words
// ------------------------------------------------------------
module fpes_array_model #(
    parameter [63:0] INIT = 64'hFFF0_FFFF_FFFF_0FFF
) (
    input  wire logic        i_clk,         // Clock
    input  wire logic [24:0] i_arr_addr,    // Array address
    output wire logic [7:0]  o_blk_of_addr, // Block of address
    input  wire logic        i_pgm_req,     // Program strobe
    input  wire logic [19:0] i_pgm_page,    // Program page
    input  wire logic [63:0] i_pgm_data,    // Program data
    input  wire logic        i_ers_req,     // Erase strobe
    input  wire logic [7:0]  i_ers_blocks   // Erase mask
);
    logic [63:0] mem [0:15];
    integer      k;
    integer      j;
    initial for (k = 0; k < 16; k = k + 1) mem[k] = INIT;
    assign o_blk_of_addr = 8'h01 << i_arr_addr[6:4];
    always @(posedge i_clk) begin
        if (i_pgm_req) mem[i_pgm_page[3:0]] <= mem[i_pgm_page[3:0]] & i_pgm_data;
        if (i_ers_req) for (j = 0; j < 8; j = j + 1) if (i_ers_blocks[j]) begin
            mem[2*j] <= 64'hFFFF_FFFF_FFFF_FFFF;
            mem[2*j+1] <= 64'hFFFF_FFFF_FFFF_FFFF;
        end
    end
endmodule // fpes_array_model
`default_nettype wire

// ==== bench/fpes_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpes_consts.vh"
// ------------------------------------------------------------
// Port checker for the program and erase sequencer
// ------------------------------------------------------------
module fpes_props #(
    parameter NBLK    = 8,
    parameter SUS_CYC = 125,
    parameter ABT_CYC = 50
) (
    input wire            i_clk,        // Clock
    input wire            i_rst_n,      // Reset, active low
    input wire [7:0]      i_reg_addr,   // Register address
    input wire [31:0]     i_reg_wdata,  // Register write data
    input wire            i_reg_wr,     // Register write
    input wire            i_reg_rd,     // Register read
    input wire [31:0]     o_reg_rdata,  // Register read data
    input wire            i_arr_rd,     // Array read
    input wire            o_arr_rd_ok,  // Array read valid
    input wire            o_pgm_req,    // Program strobe
    input wire [19:0]     o_pgm_page,   // Program page
    input wire [1:0]      o_pgm_space,  // Program space
    input wire [63:0]     o_pgm_data,   // Program data
    input wire            o_ers_req,    // Erase strobe
    input wire [NBLK-1:0] o_ers_blocks, // Erase mask
    input wire            o_ers_shadow, // Shadow erase
    input wire            o_busy        // Operation active
);
    localparam int SUS_MAX = SUS_CYC + 3;
    localparam int ABT_MAX = ABT_CYC + 3;
    reg  [NBLK-1:0] sel_q;
    reg  [NBLK-1:0] lck_q;
    reg  [NBLK-1:0] dis_q;
    wire            mcr_wr = i_reg_wr && (i_reg_addr == `FPES_ADDR_MCR);
    // Shadow copy of block select, lock and disable while not busy
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            sel_q <= {NBLK{1'b0}};
            lck_q <= {NBLK{1'b0}};
            dis_q <= {NBLK{1'b0}};
        end else if (i_reg_wr && !o_busy) begin
            if (i_reg_addr == `FPES_ADDR_BLKSEL) sel_q <= i_reg_wdata[NBLK-1:0];
            if (i_reg_addr == `FPES_ADDR_LOCK) lck_q <= i_reg_wdata[NBLK-1:0];
            if (i_reg_addr == `FPES_ADDR_DISABLE) dis_q <= i_reg_wdata[NBLK-1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_pgm_pulse; o_pgm_req |=> !o_pgm_req; endproperty
    a_pgm_pulse: assert property (p_pgm_pulse) else $error("program strobe too long");
    property p_req_busy; (o_pgm_req || o_ers_req) |-> o_busy; endproperty
    a_req_busy: assert property (p_req_busy) else $error("strobe outside busy");
    property p_no_test; o_pgm_req |-> o_pgm_space != `FPES_SPACE_TEST; endproperty
    a_no_test: assert property (p_no_test) else $error("test space programmed");
    property p_freeze; o_busy && $past(o_busy) |-> $stable(o_pgm_page) && $stable(o_pgm_data) && $stable(o_ers_blocks); endproperty
    a_freeze: assert property (p_freeze) else $error("operand changed while busy");
    property p_ers_mask; o_ers_req && !o_ers_shadow |-> o_ers_blocks == (sel_q & ~lck_q & ~dis_q); endproperty
    a_ers_mask: assert property (p_ers_mask) else $error("wrong erase mask");
    property p_sus_lat; mcr_wr && i_reg_wdata[2:0] == 3'h7 && o_busy |-> ##[1:SUS_MAX] !o_busy; endproperty
    a_sus_lat: assert property (p_sus_lat) else $error("suspend too slow");
    property p_abort; mcr_wr && i_reg_wdata[1:0] == 2'h0 && o_busy |-> ##[1:ABT_MAX] !o_busy; endproperty
    a_abort: assert property (p_abort) else $error("abort too slow");
    property p_rww; i_arr_rd && o_busy |=> !o_arr_rd_ok; endproperty
    a_rww: assert property (p_rww) else $error("read valid during modify");
    property p_done_low; $past(i_reg_rd) && $past(i_reg_addr) == `FPES_ADDR_MCR && $past(o_busy) |-> !o_reg_rdata[10]; endproperty
    a_done_low: assert property (p_done_low) else $error("done high while busy");
    c_pgm: cover property (o_pgm_req);
    c_ers: cover property (o_ers_req);
    c_abort: cover property (mcr_wr && i_reg_wdata[1:0] == 2'h0 && o_busy);
endmodule // fpes_props
`default_nettype wire

// ==== bench/fpes_sequencer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "fpes_consts.vh"
// ------------------------------------------------------------
// Program, erase, abort and suspend sequences
// ------------------------------------------------------------
module fpes_sequencer_tb;
    localparam [7:0]  A_MCR = `FPES_ADDR_MCR;
    localparam [63:0] INIT  = 64'hFFF0_FFFF_FFFF_0FFF;
    localparam [63:0] ONES  = {2{`FPES_ERASED_WORD}};
    logic        i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_arr_wr, i_arr_wide, i_arr_rd, ok;
    logic [7:0]  i_reg_addr, cap_blk;
    logic [31:0] i_reg_wdata, rv;
    logic [24:0] i_arr_addr;
    logic [63:0] i_arr_wdata, cap_data;
    logic [19:0] cap_page;
    logic [1:0]  cap_space;
    wire  [7:0]  i_blk_of_addr, o_ers_blocks;
    wire  [31:0] o_reg_rdata;
    wire  [19:0] o_pgm_page;
    wire  [1:0]  o_pgm_space;
    wire  [63:0] o_pgm_data;
    wire         o_arr_rd_ok, o_pgm_req, o_ers_req, o_ers_shadow, o_busy;
    integer      pg_cnt, err_total, n_checks, i, k, pc;
    fpes_sequencer #(.NBLK(8), .PGM_CYC(20), .ERS_CYC(20), .SUS_CYC(10), .ABT_CYC(5)) uut (
        .i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_arr_addr,
        .i_arr_wdata, .i_arr_wr, .i_arr_wide, .i_arr_rd, .o_arr_rd_ok, .i_blk_of_addr, .o_pgm_req,
        .o_pgm_page, .o_pgm_space, .o_pgm_data, .o_ers_req, .o_ers_blocks, .o_ers_shadow, .o_busy);
    fpes_array_model #(.INIT(INIT)) arr (.i_clk, .i_arr_addr, .o_blk_of_addr(i_blk_of_addr),
        .i_pgm_req(o_pgm_req), .i_pgm_page(o_pgm_page), .i_pgm_data(o_pgm_data),
        .i_ers_req(o_ers_req), .i_ers_blocks(o_ers_blocks));
    always @(posedge i_clk) begin
        if (o_pgm_req) begin
            pg_cnt <= pg_cnt + 1;
            cap_data <= o_pgm_data;
            cap_page <= o_pgm_page;
            cap_space <= o_pgm_space;
        end
        if (o_ers_req) cap_blk <= o_ers_blocks;
    end
    task chk(input [63:0] got, input [63:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_wdata <= d;
            i_reg_wr <= 1'b1;
            @(posedge i_clk);
            i_reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_rd <= 1'b1;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            #1 rv = o_reg_rdata;
        end
    endtask
    // Narrow writes carry a changing pattern in the unused half
    task awr(input [24:0] a, input [63:0] d, input w);
        begin
            @(posedge i_clk);
            i_arr_addr <= a;
            i_arr_wdata <= w ? d : {~d[31:0], d[31:0]};
            i_arr_wide <= w;
            i_arr_wr <= 1'b1;
            @(posedge i_clk);
            i_arr_wr <= 1'b0;
        end
    endtask
    task ard(input [24:0] a);
        begin
            @(posedge i_clk);
            i_arr_addr <= a;
            i_arr_rd <= 1'b1;
            @(posedge i_clk);
            i_arr_rd <= 1'b0;
            #1 ok = o_arr_rd_ok;
        end
    endtask
    task wait_done;
        begin
            rd(A_MCR);
            for (k = 0; k < 100 && rv[10] !== 1'b1; k = k + 1) rd(A_MCR);
        end
    endtask
    task seq(input [31:0] s, input [24:0] a, input [63:0] d, input w);
        begin
            wr(A_MCR, s);
            awr(a, d, w);
            wr(A_MCR, s | 32'h1);
            wait_done;
        end
    endtask
    task results;
        begin
            $display("checks=%0d mismatches=%0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    initial begin
        #200000 err_total = err_total + 1;
        results;
    end
    initial begin
        {i_rst_n, i_reg_wr, i_reg_rd, i_arr_wr, i_arr_wide, i_arr_rd} = 6'h00;
        {i_reg_addr, i_reg_wdata, i_arr_addr, i_arr_wdata} = 129'h0;
        {pg_cnt, err_total, n_checks} = 96'h0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        chk(o_pgm_data, ONES);
        wr(8'hFC, 32'hFFFF_FFFF);
        rd(A_MCR);
        chk(rv, 32'h0000_0400);
        wr(`FPES_ADDR_LOCK, 32'h0);
        wr(`FPES_ADDR_DISABLE, 32'h0);
        $display("reset test done");
        wr(A_MCR, 32'h10);
        awr(25'h00AAA8, 64'h1111_2222, 1'b0);
        awr(25'h00BAAC, 64'hAA55_AA55, 1'b0);
        awr(25'h00FFF8, 64'h55AA_55AA, 1'b0);
        wr(A_MCR, 32'h11);
        wait_done;
        chk(rv, 32'h0000_0611);
        chk({cap_page, cap_data}, {20'h01555, 64'hAA55_AA55_55AA_55AA});
        chk(arr.mem[5], INIT & 64'hAA55_AA55_55AA_55AA);
        rd(`FPES_ADDR_PGMADDR);
        chk(rv, 32'h0000_5554);
        wr(A_MCR, 32'h10);
        for (i = 0; i < 2; i = i + 1) begin
            seq(32'h10, i ? 25'h0800050 : 25'h0000044, i ? 64'h0123_4567_89AB_CDEF : 64'h0F0F_0F0F, i);
            chk(rv, i ? 32'h0000_0711 : 32'h0000_0611);
            chk(cap_data, i ? 64'h0123_4567_89AB_CDEF : 64'h0F0F_0F0F_FFFF_FFFF);
            chk(cap_space, i);
            wr(A_MCR, 32'h10);
        end
        $display("program test done");
        wr(`FPES_ADDR_LOCK, 32'h02);
        pc = pg_cnt;
        for (i = 0; i < 2; i = i + 1) begin
            seq(32'h10, i ? 25'h1000020 : 25'h0000010, 64'h0, 1'b1);
            chk(pg_cnt, pc);
            wr(A_MCR, 32'h10);
        end
        wr(A_MCR, 32'h11);
        rd(A_MCR);
        chk({rv[10], o_busy, pg_cnt}, {2'b10, pc});
        wr(A_MCR, 32'h10);
        wr(A_MCR, 32'h0);
        $display("refusal test done");
        wr(A_MCR, 32'h10);
        awr(25'h0000060, 64'h0, 1'b1);
        wr(A_MCR, 32'h11);
        ard(25'h0000060);
        chk(ok, 1'b0);
        wr(A_MCR, 32'h10);
        wait_done;
        chk(rv, 32'h0000_0C10);
        wr(A_MCR, 32'h800);
        rd(A_MCR);
        chk(rv, 32'h0000_0400);
        $display("abort test done");
        wr(`FPES_ADDR_BLKSEL, 32'h0E);
        wr(`FPES_ADDR_LOCK, 32'h04);
        wr(`FPES_ADDR_DISABLE, 32'h08);
        seq(32'h04, 25'h0, 64'hDEAD_BEEF, 1'b0);
        chk(rv, 32'h0000_0605);
        chk({cap_blk, arr.mem[2], arr.mem[4]}, {8'h02, ONES, INIT});
        wr(A_MCR, 32'h04);
        wr(`FPES_ADDR_BLKSEL, 32'h01);
        awr(25'h0, 64'h0, 1'b1);
        wr(A_MCR, 32'h05);
        wr(A_MCR, 32'h07);
        wait_done;
        chk({rv[10], rv[2:0]}, 4'hF);
        wr(A_MCR, 32'h06);
        rd(A_MCR);
        chk(rv[2:0], 3'h7);
        ard(25'h0000000);
        chk(ok, 1'b0);
        ard(25'h0000030);
        chk(ok, 1'b1);
        wr(A_MCR, 32'h05);
        wait_done;
        chk({rv, arr.mem[0]}, {32'h0000_0605, ONES});
        wr(A_MCR, 32'h04);
        awr(25'h0800000, 64'h0, 1'b1);
        wr(A_MCR, 32'h05);
        wr(`FPES_ADDR_BLKSEL, 32'hFF);
        rd(`FPES_ADDR_BLKSEL);
        chk(rv, 32'h0000_0001);
        wr(A_MCR, 32'h04);
        wait_done;
        chk(rv, 32'h0000_0404);
        chk({o_ers_shadow, cap_blk}, 9'h100);
        wr(A_MCR, 32'h0);
        $display("erase test done");
        results;
    end
endmodule // fpes_sequencer_tb
bind fpes_sequencer fpes_props #(.NBLK(NBLK), .SUS_CYC(SUS_CYC), .ABT_CYC(ABT_CYC)) u_props (
    .i_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_arr_rd,
    .o_arr_rd_ok, .o_pgm_req, .o_pgm_page, .o_pgm_space, .o_pgm_data, .o_ers_req, .o_ers_blocks,
    .o_ers_shadow, .o_busy);
`default_nettype wire

// ==== core/fpes_consts.vh ====
`ifndef FPES_CONSTS_VH
`define FPES_CONSTS_VH
// Register addresses (byte)
`define FPES_ADDR_MCR        8'h00
`define FPES_ADDR_BLKSEL     8'h04
`define FPES_ADDR_LOCK       8'h08
`define FPES_ADDR_DISABLE    8'h0C
`define FPES_ADDR_PGMADDR    8'h10
`define FPES_ADDR_PGMLO      8'h14
`define FPES_ADDR_PGMHI      8'h18
// Module config register bit positions
`define FPES_BIT_EHV         0
`define FPES_BIT_ERASE_SUSPEND_REQUEST        1
`define FPES_BIT_ERS         2
`define FPES_BIT_PGM         4
`define FPES_BIT_TARGET_SPACE_INDICATOR        8
`define FPES_BIT_PEG         9
`define FPES_BIT_DONE        10
`define FPES_BIT_RWE         11
// Array address fields
`define FPES_PAGE_MSB        22
`define FPES_PAGE_LSB        3
`define FPES_WSEL_BIT        2
`define FPES_SPACE_MSB       24
`define FPES_SPACE_LSB       23
// Address space encodings
`define FPES_SPACE_NORMAL    2'h0
`define FPES_SPACE_SHADOW    2'h1
`define FPES_SPACE_TEST      2'h2
// Defaults
`define FPES_ERASED_WORD     32'hFFFFFFFF
// Timing
`define FPES_PGM_TIME_NS     20000
`define FPES_ERS_BLK_TIME_NS 40000
`define FPES_SUS_LAT_NS      1000
`define FPES_ABORT_TIME_NS   400
`define FPES_CLK_PERIOD_NS   8
`endif

// ==== core/fpes_sequencer.v ====
`timescale 1ns/1ns
`default_nettype none
`include "fpes_consts.vh"
module fpes_sequencer #(
    parameter NBLK       = 8,
    parameter PGM_CYC    = `FPES_PGM_TIME_NS / `FPES_CLK_PERIOD_NS,
    parameter ERS_CYC    = `FPES_ERS_BLK_TIME_NS / `FPES_CLK_PERIOD_NS,
    parameter SUS_CYC    = `FPES_SUS_LAT_NS / `FPES_CLK_PERIOD_NS,
    parameter ABT_CYC    = `FPES_ABORT_TIME_NS / `FPES_CLK_PERIOD_NS
) (
    input  wire            i_clk,        // Clock, 125 MHz
    input  wire            i_rst_n,      // Synchronous reset, active low
    input  wire [7:0]      i_reg_addr,   // Register byte address
    input  wire [31:0]     i_reg_wdata,  // Register write data
    input  wire            i_reg_wr,     // Register write strobe
    input  wire            i_reg_rd,     // Register read strobe
    output reg  [31:0]     o_reg_rdata,  // Register read data, one cycle later
    input  wire [24:0]     i_arr_addr,   // Array byte address
    input  wire [63:0]     i_arr_wdata,  // Array write data
    input  wire            i_arr_wr,     // Array write strobe
    input  wire            i_arr_wide,   // Array write carries 64 bits
    input  wire            i_arr_rd,     // Array read strobe
    output reg             o_arr_rd_ok,  // Array read data valid
    input  wire [NBLK-1:0] i_blk_of_addr,// Block hit by current array address
    output reg             o_pgm_req,    // Pulse: program double word into array
    output reg  [19:0]     o_pgm_page,   // Page address bits 22..3
    output reg  [1:0]      o_pgm_space,  // Target address space
    output reg  [63:0]     o_pgm_data,   // Program data, zeros clear bits
    output reg             o_ers_req,    // Pulse: erase block mask
    output reg  [NBLK-1:0] o_ers_blocks, // Blocks to erase
    output reg             o_ers_shadow, // Erase targets shadow sector
    output reg             o_busy        // Modify operation active
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_PGM   = 3'h1;
    localparam ST_ERS   = 3'h2;
    localparam ST_SUSP  = 3'h3;
    localparam ST_ABORT = 3'h4;
    localparam ST_SUSW  = 3'h5;
    localparam TW = 24;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg            pgm_sel_reg, ers_sel_reg, hv_en_reg, sus_reg;
    reg            done_reg, good_reg, rwe_reg, target_space_indicator_reg;
    reg [NBLK-1:0] blksel_reg, lock_reg, dis_reg;
    reg [2:0]      state_reg;
    reg            ilk_reg, ers_ilk_reg, hv_was_pgm_reg;
    reg [19:0]     page_reg;
    reg [1:0]      space_reg;
    reg [31:0]     wlo_reg, whi_reg;
    reg            tload;
    reg [TW-1:0]   tcount;
    wire           texp;

    function is_addr;
        input [7:0] a;
        input [7:0] r;
        begin
            is_addr = (a == r);
        end
    endfunction

    fpes_timer #(.W(TW)) u_timer (
        .i_clk    (i_clk),
        .i_rst_n  (i_rst_n),
        .i_load   (tload),
        .i_count  (tcount),
        .i_run    (state_reg != ST_SUSP && state_reg != ST_IDLE),
        .o_expired(texp)
    );

    wire mcr_wr  = i_reg_wr && is_addr(i_reg_addr, `FPES_ADDR_MCR);
    wire w_pgm   = i_reg_wdata[`FPES_BIT_PGM];
    wire w_ers   = i_reg_wdata[`FPES_BIT_ERS];
    wire w_hv    = i_reg_wdata[`FPES_BIT_EHV];
    wire w_sus   = i_reg_wdata[`FPES_BIT_ERASE_SUSPEND_REQUEST];
    wire running = (state_reg == ST_PGM) || (state_reg == ST_ERS) ||
                   (state_reg == ST_ABORT) || (state_reg == ST_SUSW);
    wire frozen  = hv_en_reg && !done_reg;  // Operands locked while operating
    wire [NBLK-1:0] ers_mask = blksel_reg & ~lock_reg & ~dis_reg;
    wire addr_locked = |(i_blk_of_addr & (lock_reg | dis_reg));
    wire [1:0] wr_space = i_arr_addr[`FPES_SPACE_MSB:`FPES_SPACE_LSB];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            pgm_sel_reg    <= 1'b0;
            ers_sel_reg    <= 1'b0;
            hv_en_reg      <= 1'b0;
            sus_reg        <= 1'b0;
            done_reg       <= 1'b1;
            good_reg       <= 1'b0;
            rwe_reg        <= 1'b0;
            target_space_indicator_reg       <= 1'b0;
            blksel_reg     <= {NBLK{1'b0}};
            lock_reg       <= {NBLK{1'b0}};
            dis_reg        <= {NBLK{1'b0}};
            state_reg      <= ST_IDLE;
            ilk_reg        <= 1'b0;
            ers_ilk_reg    <= 1'b0;
            hv_was_pgm_reg <= 1'b0;
            page_reg       <= 20'h00000;
            space_reg      <= `FPES_SPACE_NORMAL;
            wlo_reg        <= `FPES_ERASED_WORD;
            whi_reg        <= `FPES_ERASED_WORD;
            tload          <= 1'b0;
            tcount         <= {TW{1'b0}};
            o_pgm_req      <= 1'b0;
            o_pgm_page     <= 20'h00000;
            o_pgm_space    <= 2'h0;
            o_pgm_data     <= 64'hFFFFFFFFFFFFFFFF;
            o_ers_req      <= 1'b0;
            o_ers_blocks   <= {NBLK{1'b0}};
            o_ers_shadow   <= 1'b0;
            o_busy         <= 1'b0;
            o_arr_rd_ok    <= 1'b0;
            o_reg_rdata    <= 32'h00000000;
        end else begin
            tload     <= 1'b0;
            o_pgm_req <= 1'b0;
            o_ers_req <= 1'b0;
            o_arr_rd_ok <= i_arr_rd && !running && !(state_reg == ST_SUSP && |(i_blk_of_addr & ers_mask));
            if (i_arr_rd && running) begin
                rwe_reg <= 1'b1;
            end else if (mcr_wr && i_reg_wdata[`FPES_BIT_RWE]) begin
                rwe_reg <= 1'b0;                                    // Write one to clear
            end
            // Register writes
            if (i_reg_wr && !frozen) begin
                if (is_addr(i_reg_addr, `FPES_ADDR_BLKSEL)) blksel_reg <= i_reg_wdata[NBLK-1:0];
                if (is_addr(i_reg_addr, `FPES_ADDR_LOCK))   lock_reg   <= i_reg_wdata[NBLK-1:0];
                if (is_addr(i_reg_addr, `FPES_ADDR_DISABLE))dis_reg    <= i_reg_wdata[NBLK-1:0];
            end
            if (mcr_wr && state_reg != ST_SUSP && state_reg != ST_SUSW) begin
                if (!hv_en_reg) begin
                    pgm_sel_reg <= w_pgm && !ers_sel_reg;
                    ers_sel_reg <= w_ers && !pgm_sel_reg;
                    if ((w_pgm && !pgm_sel_reg) || (w_ers && !ers_sel_reg) || (!w_pgm && !w_ers)) begin
                        ilk_reg     <= 1'b0;
                        ers_ilk_reg <= 1'b0;
                        if (w_pgm && !pgm_sel_reg) begin
                            wlo_reg <= `FPES_ERASED_WORD;
                            whi_reg <= `FPES_ERASED_WORD;
                        end
                    end
                end
            end
            // Array writes during selection build the operands
            if (i_arr_wr && !hv_en_reg && pgm_sel_reg) begin
                if (!ilk_reg) begin
                    ilk_reg   <= 1'b1;
                    page_reg  <= i_arr_addr[`FPES_PAGE_MSB:`FPES_PAGE_LSB];
                    space_reg <= wr_space;
                    target_space_indicator_reg  <= (wr_space != `FPES_SPACE_NORMAL);
                    hv_was_pgm_reg <= addr_locked;
                end
                if (i_arr_wide) begin
                    wlo_reg <= i_arr_wdata[31:0];
                    whi_reg <= i_arr_wdata[63:32];
                end else if (i_arr_addr[`FPES_WSEL_BIT]) begin
                    whi_reg <= i_arr_wdata[31:0];
                end else begin
                    wlo_reg <= i_arr_wdata[31:0];
                end
            end
            if (i_arr_wr && !hv_en_reg && ers_sel_reg) begin
                ers_ilk_reg <= 1'b1;                                // Data discarded
                o_ers_shadow <= (wr_space == `FPES_SPACE_SHADOW);
            end
            case (state_reg)
            ST_IDLE: begin
                if (mcr_wr && w_hv && !hv_en_reg) begin
                    hv_en_reg <= 1'b1;
                    if (pgm_sel_reg && w_pgm && ilk_reg) begin
                        done_reg  <= 1'b0;
                        good_reg  <= 1'b0;
                        state_reg <= ST_PGM;
                        tload     <= 1'b1;
                        tcount    <= PGM_CYC[TW-1:0];
                        o_busy    <= 1'b1;
                        o_pgm_req  <= !hv_was_pgm_reg && space_reg != `FPES_SPACE_TEST;
                        o_pgm_page <= page_reg;
                        o_pgm_space<= space_reg;
                        o_pgm_data <= {whi_reg, wlo_reg};
                    end else if (ers_sel_reg && w_ers && ers_ilk_reg) begin
                        done_reg  <= 1'b0;
                        good_reg  <= 1'b0;
                        state_reg <= ST_ERS;
                        tload     <= 1'b1;
                        tcount    <= ERS_CYC[TW-1:0];
                        o_busy    <= 1'b1;
                        o_ers_req <= 1'b1;
                        o_ers_blocks <= o_ers_shadow ? {NBLK{1'b0}} : ers_mask;
                    end
                    // Otherwise no operation; done stays high
                end else if (mcr_wr && !w_hv && hv_en_reg) begin
                    hv_en_reg <= 1'b0;
                    if (pgm_sel_reg) begin
                        ilk_reg <= 1'b0;                            // Next program begins
                        wlo_reg <= `FPES_ERASED_WORD;
                        whi_reg <= `FPES_ERASED_WORD;
                    end
                    ers_ilk_reg <= 1'b0;
                end
            end
            ST_PGM, ST_ERS: begin
                if (mcr_wr && !w_hv) begin
                    hv_en_reg <= 1'b0;
                    state_reg <= ST_ABORT;
                    tload     <= 1'b1;
                    tcount    <= ABT_CYC[TW-1:0];
                end else if (state_reg == ST_ERS && mcr_wr && w_sus && !sus_reg && !pgm_sel_reg) begin
                    sus_reg   <= 1'b1;
                    state_reg <= ST_SUSW;
                    tload     <= 1'b1;
                    tcount    <= SUS_CYC[TW-1:0];
                end else if (texp && !tload) begin
                    state_reg <= ST_IDLE;
                    done_reg  <= 1'b1;
                    good_reg  <= 1'b1;
                    o_busy    <= 1'b0;
                end
            end
            ST_SUSW: begin
                if (texp && !tload) begin
                    state_reg <= ST_SUSP;
                    done_reg  <= 1'b1;                              // Within latency bound
                    o_busy    <= 1'b0;
                end
            end
            ST_SUSP: begin
                // Program/erase refused, high voltage clear ignored
                if (mcr_wr && !w_sus && hv_en_reg && w_hv) begin
                    sus_reg   <= 1'b0;                              // Resume from restart point
                    done_reg  <= 1'b0;
                    o_busy    <= 1'b1;
                    state_reg <= ST_ERS;
                    tload     <= 1'b1;
                    tcount    <= ERS_CYC[TW-1:0];
                end
            end
            ST_ABORT: begin
                if (texp && !tload) begin
                    state_reg <= ST_IDLE;
                    done_reg  <= 1'b1;
                    good_reg  <= 1'b0;
                    o_busy    <= 1'b0;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
            endcase
            // Register read data
            o_reg_rdata <= 32'h00000000;
            if (i_reg_rd) begin
                if (is_addr(i_reg_addr, `FPES_ADDR_MCR)) begin
                    o_reg_rdata[`FPES_BIT_EHV]  <= hv_en_reg;
                    o_reg_rdata[`FPES_BIT_ERASE_SUSPEND_REQUEST] <= sus_reg;
                    o_reg_rdata[`FPES_BIT_ERS]  <= ers_sel_reg;
                    o_reg_rdata[`FPES_BIT_PGM]  <= pgm_sel_reg;
                    o_reg_rdata[`FPES_BIT_TARGET_SPACE_INDICATOR] <= target_space_indicator_reg;
                    o_reg_rdata[`FPES_BIT_PEG]  <= good_reg;
                    o_reg_rdata[`FPES_BIT_DONE] <= done_reg;
                    o_reg_rdata[`FPES_BIT_RWE]  <= rwe_reg;
                end
                if (is_addr(i_reg_addr, `FPES_ADDR_BLKSEL))  o_reg_rdata[NBLK-1:0] <= blksel_reg;
                if (is_addr(i_reg_addr, `FPES_ADDR_LOCK))    o_reg_rdata[NBLK-1:0] <= lock_reg;
                if (is_addr(i_reg_addr, `FPES_ADDR_DISABLE)) o_reg_rdata[NBLK-1:0] <= dis_reg;
                if (is_addr(i_reg_addr, `FPES_ADDR_PGMADDR)) o_reg_rdata <= {10'h000, page_reg, space_reg};
                if (is_addr(i_reg_addr, `FPES_ADDR_PGMLO))   o_reg_rdata <= wlo_reg;
                if (is_addr(i_reg_addr, `FPES_ADDR_PGMHI))   o_reg_rdata <= whi_reg;
            end
        end
    end
endmodule // fpes_sequencer
`default_nettype wire

// ==== core/fpes_timer.v ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Down counter for high-voltage phase timing
// ------------------------------------------------------------
module fpes_timer #(
    parameter W = 16
) (
    input  wire         i_clk,    // Clock
    input  wire         i_rst_n,  // Synchronous reset, active low
    input  wire         i_load,   // Load count
    input  wire [W-1:0] i_count,  // Cycles to count
    input  wire         i_run,    // Count enable
    output wire         o_expired // Count reached zero
);
    reg [W-1:0] cnt_reg;
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt_reg <= {W{1'b0}};
        end else if (i_load) begin
            cnt_reg <= i_count;
        end else if (i_run && cnt_reg != {W{1'b0}}) begin
            cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign o_expired = (cnt_reg == {W{1'b0}});
endmodule // fpes_timer
`default_nettype wire
